// file: rtc_defines.svh
// register map, field positions, reset values and timing counts
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// register addresses on the serial link
`define RTC_ADDR_SEC       4'h0
`define RTC_ADDR_MIN       4'h1
`define RTC_ADDR_HOUR      4'h2
`define RTC_ADDR_WDAY      4'h3
`define RTC_ADDR_CTRL1     4'hE
`define RTC_ADDR_CTRL2     4'hF

// control register 1 fields
`define RTC_C1_WKEN        7
`define RTC_C1_DYEN        6
`define RTC_C1_M24         5
`define RTC_C1_DISB        4
`define RTC_C1_TEST        3

// control register 2 fields
`define RTC_C2_VTHSEL      7
`define RTC_C2_HALT        5
`define RTC_C2_PWRON       4
`define RTC_C2_DISA        3
`define RTC_C2_PFLAG       2
`define RTC_C2_WKFLAG      1
`define RTC_C2_DYFLAG      0

// reset values
`define RTC_CTRL_RST       1'h0
`define RTC_PWRON_RST      1'h1
`define RTC_TIME_RST       8'h00

// timing
`define RTC_XTAL_HZ        32768
`define RTC_ALARM_DELAY_NS 31000
`define RTC_CLK_PERIOD_NS  8
`define RTC_ALARM_DELAY_CYC \
  ((`RTC_ALARM_DELAY_NS + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS)

// serial frame positions, counted in rising edges of the link clock
`define RTC_LNK_CMD_LAST   5'h07
`define RTC_LNK_RD_BIT     3
`define RTC_LNK_RD_LOAD    5'h09
`define RTC_LNK_WR_LAST    5'h0F
`define RTC_LNK_RD_END     5'h11

`endif

// file: rtc_pkg.sv
// shared types of the real-time clock core
package rtc_pkg;

  // periodic output selection, in register encoding order
  typedef enum logic [2:0] {
    PM_OFF,
    PM_LOW,
    PM_2HZ,
    PM_1HZ,
    PM_SEC,
    PM_MIN,
    PM_HOUR,
    PM_MONTH
  } rtc_pmode_t;

endpackage

// file: rtc_alarm_flag.sv
// alarm flag with match-to-flag delay and write-zero clear
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_alarm_flag #(
  parameter int DELAY_CYC = `RTC_ALARM_DELAY_CYC
) (
  // system
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // control
  input  wire logic i_match,
  input  wire logic i_enable,
  input  wire logic i_clear,
  // flag
  output logic      o_flag
);
  import rtc_pkg::*;

  localparam int CW = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] C_LAST = CW'(DELAY_CYC - 1);

  logic [CW-1:0] cnt;
  logic          busy;
  logic          fire;

  assign fire = busy && (cnt == C_LAST);

  // a match during a running delay is folded into the same flag event
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_enable) begin
      busy <= 1'h0;
      cnt  <= '0;
    end else if (!busy) begin
      busy <= i_match;
      cnt  <= '0;
    end else if (fire) begin
      busy <= 1'h0;
    end else begin
      cnt <= cnt + 1'h1;
    end
  end

  // set wins over a clear landing in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      o_flag <= 1'h0;
    else if (!i_enable)
      o_flag <= 1'h0;
    else if (fire)
      o_flag <= 1'h1;
    else if (i_clear)
      o_flag <= 1'h0;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  chk_alarm_delay: assert property (
    (fire && i_enable) |=> o_flag)
    else $error("alarm flag not set after delay");
  chk_alarm_clear: assert property (
    (i_clear && !fire && i_enable) |=> !o_flag)
    else $error("alarm flag not cleared by write");
  chk_alarm_gated: assert property (
    !i_enable |=> !o_flag [*2])
    else $error("alarm flag set while disabled");

endmodule

// file: rtc_core.sv
// time-keeping core of a serial real-time clock with three-wire link
//
// What this block does
// - sub-clock pin toggles with crystal unless both disables set or pin low
// - first sub-clock disable resets to 0; writing 1 disables with other
// - periodic flag reads 1 while periodic output drives interrupt low
// - level mode: writing 0 clears periodic flag; writing 1 does nothing
// - alarm flag sets about 31 us after match, only when enabled
// - writing 0 clears alarm flag, releasing interrupt until next match
// - disabled alarm flag reads as 0
// - seconds at 0h, BCD in bits 6..0, bit 7 reads 0
// - minutes at 1h, BCD in bits 6..0, bit 7 reads 0
// - hours at 2h, bits 4..0, bit 5 PM or twenty, 7..6 zero
// - seconds count 00..59 and carry into minutes on wrap
// - minutes count 00..59 and carry into hours on wrap
// - hours carry to day counters at 11PM->12AM or 23->00
// - any seconds write clears the sub-second divider
// - weekday at 3h counts 0 to 6 then wraps, upper bits zero
// - after power-on time and weekday reset to 0 and unused bits read 0
// - one-second level mode interrupts with each seconds increment
// - power-on clears control bits except the power-on flag, which sets
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_core #(
  parameter int XTAL_HZ = `RTC_XTAL_HZ
) (
  // system
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // crystal and sub-clock
  input  wire logic i_xtal,
  input  wire logic i_subclock_control_pin,
  output logic      o_subclock_output_pin,
  // three-wire link
  input  wire logic i_sclk,
  input  wire logic i_ce,
  input  wire logic i_sio,
  output logic      o_sio,
  output logic      o_sio_oe,
  // alarm matches and calendar
  input  wire logic i_weekly_alarm_match,
  input  wire logic i_daily_alarm_match,
  input  wire logic i_month_tick,
  output logic      o_day_carry,
  output logic      o_interrupt_output_pin_n
);
  import rtc_pkg::*;

  localparam int FW = $clog2(XTAL_HZ);
  localparam logic [FW-1:0] F_LAST = FW'(XTAL_HZ - 1);
  localparam logic [FW-1:0] F_HALF = FW'(XTAL_HZ / 2);
  localparam logic [FW-1:0] F_Q    = FW'(XTAL_HZ / 4);
  localparam logic [FW-1:0] F_3Q   = FW'((XTAL_HZ / 4) * 3);

  // link domain
  logic [4:0] bit_cnt;
  logic [7:0] sh_in;
  logic [7:0] sh_out;
  logic [3:0] cmd_addr;
  logic       cmd_rd;
  logic [7:0] in_byte;
  logic       wr_tgl;
  logic       rd_tgl;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;

  // system domain
  logic            x1, x2, x3;
  logic            ck1, ck2;
  logic            ws1, ws2, ws3;
  logic            rs1, rs2, rs3;
  logic            wr_evt;
  logic            rd_evt;
  logic [7:0]      rd_word;
  logic [FW-1:0]   frac;
  logic            xt_rise;
  logic            sec_tick;
  logic            sec_wrap;
  logic            min_wrap;
  logic            hr_wrap;
  logic [7:0]      seconds;
  logic [7:0]      minutes;
  logic [7:0]      hours;
  logic [2:0]      weekday;
  logic            wk_en, dy_en, m24, dis_b, test_bit;
  rtc_pmode_t      psel;
  logic            vth_sel, osc_halt, pwr_on, dis_a;
  logic            lvl_flag;
  logic            lvl_evt;
  logic            pulse_lo;
  logic            periodic_flag;
  logic            wk_flag, dy_flag;
  logic            wr_sec, wr_min, wr_hour, wr_wday, wr_c1, wr_c2;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction

  // 12-hour order: 12AM,01..11AM,12PM,01..11PM with bit 5 marking PM
  function automatic logic [7:0] hour_next(input logic [7:0] h,
                                           input logic       mode24);
    logic [7:0] low;
    low = bcd_inc({3'h0, h[4:0]});
    if (mode24)
      hour_next = (h == 8'h23) ? 8'h00 : bcd_inc(h);
    else if (h[4:0] == 5'h12)
      hour_next = {2'h0, h[5], 5'h01};
    else if (h[4:0] == 5'h11)
      hour_next = {2'h0, ~h[5], 5'h12};
    else
      hour_next = {2'h0, h[5], low[4:0]};
  endfunction

  function automatic logic [7:0] rd_val(input logic [3:0] a);
    if (a == `RTC_ADDR_SEC)
      rd_val = {1'h0, seconds[6:0]};
    else if (a == `RTC_ADDR_MIN)
      rd_val = {1'h0, minutes[6:0]};
    else if (a == `RTC_ADDR_HOUR)
      rd_val = {2'h0, hours[5:0]};
    else if (a == `RTC_ADDR_WDAY)
      rd_val = {5'h00, weekday};
    else if (a == `RTC_ADDR_CTRL1)
      rd_val = {wk_en, dy_en, m24, dis_b, test_bit, psel};
    else if (a == `RTC_ADDR_CTRL2)
      rd_val = {vth_sel, 1'h0, osc_halt, pwr_on, dis_a, periodic_flag,
                wk_flag & wk_en, dy_flag & dy_en};
    else
      rd_val = 8'h00;
  endfunction

  // ---------------- link clock domain ----------------
  assign in_byte = {sh_in[6:0], i_sio};

  // frame state is cleared while chip enable is low
  always_ff @(posedge i_sclk or negedge i_ce or posedge i_sys_rst) begin
    if (i_sys_rst || !i_ce) begin
      bit_cnt  <= 5'h00;
      sh_in    <= 8'h00;
      cmd_addr <= 4'h0;
      cmd_rd   <= 1'h0;
    end else begin
      sh_in <= in_byte;
      if (bit_cnt != 5'h1F)
        bit_cnt <= bit_cnt + 5'h01;
      if (bit_cnt == `RTC_LNK_CMD_LAST) begin
        cmd_addr <= in_byte[7:4];
        cmd_rd   <= in_byte[`RTC_LNK_RD_BIT];
      end
    end
  end

  // toggles and write holding registers must outlive the frame
  always_ff @(posedge i_sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_tgl  <= 1'h0;
      rd_tgl  <= 1'h0;
      wr_addr <= 4'h0;
      wr_data <= 8'h00;
    end else if (i_ce) begin
      if (bit_cnt == `RTC_LNK_CMD_LAST && in_byte[`RTC_LNK_RD_BIT])
        rd_tgl <= ~rd_tgl;
      if (bit_cnt == `RTC_LNK_WR_LAST && !cmd_rd) begin
        wr_tgl  <= ~wr_tgl;
        wr_addr <= cmd_addr;
        wr_data <= in_byte;
      end
    end
  end

  // one turnaround slot gives the system side time to fetch the word
  always_ff @(negedge i_sclk or negedge i_ce or posedge i_sys_rst) begin
    if (i_sys_rst || !i_ce) begin
      sh_out   <= 8'h00;
      o_sio_oe <= 1'h0;
    end else if (cmd_rd && bit_cnt == `RTC_LNK_RD_LOAD) begin
      sh_out   <= rd_word;
      o_sio_oe <= 1'h1;
    end else if (bit_cnt > `RTC_LNK_RD_LOAD && bit_cnt < `RTC_LNK_RD_END) begin
      sh_out <= {sh_out[6:0], 1'h0};
    end else if (bit_cnt >= `RTC_LNK_RD_END) begin
      o_sio_oe <= 1'h0;
    end
  end

  assign o_sio = sh_out[7];

  // ---------------- system clock domain ----------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      {x1, x2, x3} <= 3'h0;
      {ck1, ck2}   <= 2'h0;
      {ws1, ws2, ws3} <= 3'h0;
      {rs1, rs2, rs3} <= 3'h0;
    end else begin
      {x1, x2, x3} <= {i_xtal, x1, x2};
      {ck1, ck2}   <= {i_subclock_control_pin, ck1};
      {ws1, ws2, ws3} <= {wr_tgl, ws1, ws2};
      {rs1, rs2, rs3} <= {rd_tgl, rs1, rs2};
    end
  end

  assign xt_rise = x2 & ~x3;
  assign wr_evt  = ws2 ^ ws3;
  assign rd_evt  = rs2 ^ rs3;
  assign wr_sec  = wr_evt && wr_addr == `RTC_ADDR_SEC;
  assign wr_min  = wr_evt && wr_addr == `RTC_ADDR_MIN;
  assign wr_hour = wr_evt && wr_addr == `RTC_ADDR_HOUR;
  assign wr_wday = wr_evt && wr_addr == `RTC_ADDR_WDAY;
  assign wr_c1   = wr_evt && wr_addr == `RTC_ADDR_CTRL1;
  assign wr_c2   = wr_evt && wr_addr == `RTC_ADDR_CTRL2;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      rd_word <= 8'h00;
    else if (rd_evt)
      rd_word <= rd_val(cmd_addr);
  end

  // sub-second divider of crystal edges
  assign sec_tick = xt_rise && frac == F_LAST;
  assign sec_wrap = sec_tick && seconds == 8'h59;
  assign min_wrap = sec_wrap && minutes == 8'h59;
  assign hr_wrap  = min_wrap && (m24 ? hours == 8'h23 : hours == 8'h31);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || wr_sec)
      frac <= '0;
    else if (xt_rise)
      frac <= sec_tick ? '0 : frac + 1'h1;
  end

  // a host write wins over a tick in the same cycle; invalid loads are
  // not repaired, so counters follow the BCD step from whatever is held
  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      seconds <= `RTC_TIME_RST;
    else if (wr_sec)
      seconds <= {1'h0, wr_data[6:0]};
    else if (sec_tick)
      seconds <= sec_wrap ? 8'h00 : bcd_inc(seconds);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      minutes <= `RTC_TIME_RST;
    else if (wr_min)
      minutes <= {1'h0, wr_data[6:0]};
    else if (sec_wrap)
      minutes <= min_wrap ? 8'h00 : bcd_inc(minutes);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      hours <= `RTC_TIME_RST;
    else if (wr_hour)
      hours <= {2'h0, wr_data[5:0]};
    else if (min_wrap)
      hours <= hour_next(hours, m24);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      weekday <= 3'h0;
    else if (wr_wday)
      weekday <= wr_data[2:0];
    else if (hr_wrap)
      weekday <= (weekday == 3'h6) ? 3'h0 : weekday + 3'h1;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      o_day_carry <= 1'h0;
    else
      o_day_carry <= hr_wrap;
  end

  // control registers; reset stands for power-on from zero volts
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wk_en    <= `RTC_CTRL_RST;
      dy_en    <= `RTC_CTRL_RST;
      m24      <= `RTC_CTRL_RST;
      dis_b    <= `RTC_CTRL_RST;
      test_bit <= `RTC_CTRL_RST;
      psel     <= PM_OFF;
      vth_sel  <= `RTC_CTRL_RST;
      dis_a    <= `RTC_CTRL_RST;
      pwr_on   <= `RTC_PWRON_RST;
    end else if (wr_c1) begin
      wk_en    <= wr_data[`RTC_C1_WKEN];
      dy_en    <= wr_data[`RTC_C1_DYEN];
      m24      <= wr_data[`RTC_C1_M24];
      dis_b    <= wr_data[`RTC_C1_DISB];
      test_bit <= wr_data[`RTC_C1_TEST];
      psel     <= rtc_pmode_t'(wr_data[2:0]);
    end else if (wr_c2) begin
      vth_sel <= wr_data[`RTC_C2_VTHSEL];
      dis_a   <= wr_data[`RTC_C2_DISA];
      if (!wr_data[`RTC_C2_PWRON])
        pwr_on <= 1'h0;
    end
  end

  // halt monitor bit is also cleared at power-on; no halt detector here
  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      osc_halt <= `RTC_CTRL_RST;
    else if (wr_c2)
      osc_halt <= wr_data[`RTC_C2_HALT];
  end

  // periodic output
  always_comb begin
    case (psel)
      PM_SEC:   lvl_evt = sec_tick;
      PM_MIN:   lvl_evt = sec_wrap;
      PM_HOUR:  lvl_evt = min_wrap;
      PM_MONTH: lvl_evt = i_month_tick;
      default:  lvl_evt = 1'h0;
    endcase
  end

  always_comb begin
    case (psel)
      PM_LOW:  pulse_lo = 1'h1;
      PM_2HZ:  pulse_lo = frac < F_Q || (frac >= F_HALF && frac < F_3Q);
      PM_1HZ:  pulse_lo = frac < F_HALF;
      default: pulse_lo = 1'h0;
    endcase
  end

  // the clear only acts in level mode; a new event beats the clear
  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      lvl_flag <= 1'h0;
    else if (psel >= PM_SEC && lvl_evt)
      lvl_flag <= 1'h1;
    else if (psel < PM_SEC || (wr_c2 && !wr_data[`RTC_C2_PFLAG]))
      lvl_flag <= 1'h0;
  end

  assign periodic_flag = (psel >= PM_SEC) ? lvl_flag : pulse_lo;

  rtc_alarm_flag u_weekly (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_match   (i_weekly_alarm_match),
    .i_enable  (wk_en),
    .i_clear   (wr_c2 && !wr_data[`RTC_C2_WKFLAG]),
    .o_flag    (wk_flag)
  );

  rtc_alarm_flag u_daily (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_match   (i_daily_alarm_match),
    .i_enable  (dy_en),
    .i_clear   (wr_c2 && !wr_data[`RTC_C2_DYFLAG]),
    .o_flag    (dy_flag)
  );

  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      o_interrupt_output_pin_n <= 1'h1;
    else
      o_interrupt_output_pin_n <=
        ~(periodic_flag | wk_flag | dy_flag);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      o_subclock_output_pin <= 1'h0;
    else
      o_subclock_output_pin <= x2 & ck2 & ~(dis_a & dis_b);
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_day_end;
    sec_tick && !wr_evt && m24 &&
      seconds == 8'h59 && minutes == 8'h59 && hours == 8'h23;
  endsequence

  sequence s_level_sec;
    psel == PM_SEC && sec_tick;
  endsequence

  chk_subclk_off: assert property (
    (dis_a && dis_b) || !ck2 |=> !o_subclock_output_pin)
    else $error("sub-clock driven while disabled");
  chk_pon_defaults: assert property (
    $fell(i_sys_rst) |-> pwr_on && !dis_a && psel == PM_OFF && !wk_en)
    else $error("power-on defaults wrong");
  chk_pflag_pin: assert property (
    periodic_flag |=> !o_interrupt_output_pin_n)
    else $error("periodic flag set but pin high");
  chk_pflag_clear: assert property (
    (psel >= PM_SEC && wr_c2 && !wr_data[`RTC_C2_PFLAG] && !lvl_evt)
      |=> !periodic_flag)
    else $error("periodic flag not cleared by write");
  chk_time_masks: assert property (
    (rd_evt && cmd_addr <= `RTC_ADDR_HOUR) |=> !rd_word[7])
    else $error("unused time bit read as one");
  chk_wday_mask: assert property (
    (rd_evt && cmd_addr == `RTC_ADDR_WDAY) |=> rd_word[7:3] == 5'h00)
    else $error("weekday upper bits not zero");
  chk_sec_wrap: assert property (
    (sec_wrap && !wr_evt) |=> seconds == 8'h00 && minutes != $past(minutes))
    else $error("seconds wrap without minute carry");
  chk_min_wrap: assert property (
    (min_wrap && !wr_evt) |=> minutes == 8'h00 && hours != $past(hours))
    else $error("minutes wrap without hour carry");
  chk_day_carry: assert property (
    s_day_end |=> o_day_carry && hours == 8'h00)
    else $error("day carry missing at midnight");
  chk_frac_clear: assert property (
    wr_sec |=> frac == '0)
    else $error("divider not cleared by seconds write");
  chk_wday_wrap: assert property (
    (hr_wrap && !wr_evt && weekday == 3'h6) |=> weekday == 3'h0)
    else $error("weekday did not wrap");
  chk_level_sec: assert property (
    s_level_sec |=> lvl_flag ##1 !o_interrupt_output_pin_n)
    else $error("one-second level interrupt missing");

endmodule

// file: rtc_host_model.sv
// host cpu model driving the three-wire serial link
`timescale 1ns/1ps
module rtc_host_model (
  // device side of the data line
  input  wire logic       i_dev_sio,
  input  wire logic       i_dev_sio_oe,
  // link
  output logic            o_sclk,
  output logic            o_ce,
  output logic            o_sio,
  // read results
  output logic            o_rd_stb,
  output logic [7:0]      o_rd_data
);
  localparam time HALF = 80ns;
  logic host_oe;
  logic host_bit;
  logic junk;

  // a released line shows a changing pattern, never a stale bit
  assign o_sio = i_dev_sio_oe ? i_dev_sio : (host_oe ? host_bit : junk);

  initial begin
    o_sclk    = 1'b0;
    o_ce      = 1'b0;
    host_oe   = 1'b0;
    host_bit  = 1'b0;
    junk      = 1'b0;
    o_rd_stb  = 1'b0;
    o_rd_data = 8'h00;
  end

  // one register per frame, address in the command byte
  // callers also pass the unused address 4h and set bits above the time fields
  task automatic xfer(input logic [3:0] addr, input logic rd,
                      input logic [7:0] wd);
    logic [15:0] sh;
    logic [7:0]  rx;
    sh = {addr, rd, 3'h0, wd};
    rx = 8'h00;
    o_ce = 1'b1;
    for (int k = 0; k < (rd ? 17 : 16); k++) begin
      host_oe = !rd || k < 8;
      if (k < 16)
        host_bit = sh[15 - k];
      junk = ~junk;
      #HALF;
      o_sclk = 1'b1;
      if (rd && k >= 9)
        rx = {rx[6:0], o_sio};
      #HALF;
      o_sclk = 1'b0;
    end
    #HALF;
    o_ce = 1'b0;
    host_oe = 1'b0;
    if (rd) begin
      o_rd_data = rx;
      o_rd_stb = 1'b1;
    end
    #HALF;
    o_rd_stb = 1'b0;
    #HALF;
  endtask
endmodule

// file: testbench.sv
// self-checking bench for the real-time clock core
`timescale 1ns/1ps
`include "rtc_defines.svh"
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); \
  end \
end
module testbench;
  logic        clk, rst, xtal, sub_pin, wk_match, dy_match, month_tick;
  logic        sclk, ce, sio, dev_sio, dev_oe, sub_out, day_carry, int_n;
  logic        rd_stb, last, run;
  logic [7:0]  rd_data, wd, exp_v;
  logic [7:0]  msk [4];
  logic [7:0]  val [4];
  logic [7:0]  exp_q [$];
  int          mismatches, num_checks, n;

  rtc_core #(.XTAL_HZ(16)) dut_u (
    .i_clk(clk), .i_sys_rst(rst), .i_xtal(xtal),
    .i_subclock_control_pin(sub_pin), .o_subclock_output_pin(sub_out),
    .i_sclk(sclk), .i_ce(ce), .i_sio(sio), .o_sio(dev_sio),
    .o_sio_oe(dev_oe), .i_weekly_alarm_match(wk_match),
    .i_daily_alarm_match(dy_match), .i_month_tick(month_tick),
    .o_day_carry(day_carry), .o_interrupt_output_pin_n(int_n));

  rtc_host_model host_u (
    .i_dev_sio(dev_sio), .i_dev_sio_oe(dev_oe), .o_sclk(sclk), .o_ce(ce),
    .o_sio(sio), .o_rd_stb(rd_stb), .o_rd_data(rd_data));

  always #4 clk = ~clk;
  // crystal stand-in, scaled with XTAL_HZ so a second is 6400 cycles
  always #1600 xtal = ~xtal;

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_u.xfer(a, 1'b0, d);
  endtask

  task automatic rd_exp(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.xfer(a, 1'b1, 8'h00);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge rd_stb) begin
    if (exp_q.size() == 0) begin
      mismatches++;
      $display("mismatch read data expected none seen %0h", rd_data);
    end else begin
      exp_v = exp_q.pop_front();
      `CHK("read data", exp_v, rd_data)
    end
  end

  initial begin
    #700us;
    mismatches++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    clk = 0;
    rst = 1;
    xtal = 0;
    sub_pin = 1;
    wk_match = 0;
    dy_match = 0;
    month_tick = 0;
    mismatches = 0;
    num_checks = 0;
    msk = '{8'h7F, 8'h7F, 8'h3F, 8'h07};
    val = '{8'h45, 8'h37, 8'h12, 8'h05};
    n = $urandom(56012);
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    `CHK("interrupt idle", 1'b1, int_n)
    rd_exp(`RTC_ADDR_CTRL1, 8'h00);
    rd_exp(`RTC_ADDR_CTRL2, 8'h10);
    wr(4'h4, 8'hA5);
    rd_exp(4'h4, 8'h00);
    $display("test reset done");

    // seconds first: its write clears the divider, leaving a full second
    for (int i = 0; i < 4; i++) begin
      wd = (8'($urandom) & ~msk[i]) | val[i];
      wr(i[3:0], wd);
      rd_exp(i[3:0], val[i]);
    end
    $display("test field masks done");

    for (int m = 0; m < 2; m++) begin
      wr(`RTC_ADDR_CTRL1, m ? 8'h04 : 8'h24);
      wr(`RTC_ADDR_HOUR, m ? 8'h31 : 8'h23);
      wr(`RTC_ADDR_MIN, 8'h59);
      wd = m ? 8'($urandom % 6) : 8'h06;
      wr(`RTC_ADDR_WDAY, wd);
      wr(`RTC_ADDR_SEC, 8'h59);
      n = 0;
      while (day_carry !== 1'b1 && n < 9000) begin
        @(negedge clk);
        n++;
      end
      `CHK("carry delay", 1'b1, n >= 5900 && n <= 6450)
      repeat (3) @(negedge clk);
      `CHK("periodic low", 1'b0, int_n)
      rd_exp(`RTC_ADDR_SEC, 8'h00);
      rd_exp(`RTC_ADDR_MIN, 8'h00);
      rd_exp(`RTC_ADDR_HOUR, m ? 8'h12 : 8'h00);
      rd_exp(`RTC_ADDR_WDAY, m ? wd + 8'h01 : 8'h00);
      rd_exp(`RTC_ADDR_CTRL2, m ? 8'h04 : 8'h14);
      wr(`RTC_ADDR_CTRL2, 8'h04);
      rd_exp(`RTC_ADDR_CTRL2, 8'h04);
      `CHK("flag write one", 1'b0, int_n)
      wr(`RTC_ADDR_CTRL2, 8'h00);
      repeat (8) @(negedge clk);
      `CHK("periodic released", 1'b1, int_n)
      $display("test rollover %0d done", m);
    end

    // weekly alarm enabled, daily left disabled throughout
    wr(`RTC_ADDR_CTRL1, 8'h80);
    for (int k = 0; k < 3; k++) begin
      @(negedge clk);
      wk_match = 1'b1;
      dy_match = 1'b1;
      @(negedge clk);
      wk_match = 1'b0;
      dy_match = 1'b0;
      n = 0;
      while (int_n !== 1'b0 && n < 6000) begin
        @(negedge clk);
        n++;
      end
      `CHK("alarm delay", 1'b1, n >= 3860 && n <= 3890)
      rd_exp(`RTC_ADDR_CTRL2, 8'h02);
      if (k == 2)
        wr(`RTC_ADDR_CTRL1, 8'h00);
      else
        wr(`RTC_ADDR_CTRL2, 8'h01);
      repeat (8) @(negedge clk);
      `CHK("alarm released", 1'b1, int_n)
      rd_exp(`RTC_ADDR_CTRL2, 8'h00);
      $display("test alarm %0d done", k);
    end

    for (int c = 0; c < 8; c++) begin
      wr(`RTC_ADDR_CTRL2, {4'h0, c[0], 3'h0});
      wr(`RTC_ADDR_CTRL1, {3'h0, c[1], 4'h0});
      @(negedge clk);
      sub_pin = c[2];
      repeat (10) @(negedge clk);
      n = 0;
      last = sub_out;
      repeat (1600) begin
        @(negedge clk);
        if (sub_out !== last)
          n++;
        last = sub_out;
      end
      run = c[2] & ~(c[0] & c[1]);
      `CHK("subclock running", run, n >= 6)
      if (!run)
        `CHK("subclock low", 1'b0, sub_out)
    end
    $display("test subclock done");

    // fixed-low pulse mode ignores the flag clear; month level mode
    wr(`RTC_ADDR_CTRL2, 8'h00);
    wr(`RTC_ADDR_CTRL1, 8'h01);
    `CHK("fixed low", 1'b0, int_n)
    wr(`RTC_ADDR_CTRL2, 8'h00);
    rd_exp(`RTC_ADDR_CTRL2, 8'h04);
    wr(`RTC_ADDR_CTRL1, 8'h07);
    repeat (4) @(negedge clk);
    `CHK("month idle", 1'b1, int_n)
    month_tick = 1'b1;
    @(negedge clk);
    month_tick = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("month low", 1'b0, int_n)
    rd_exp(`RTC_ADDR_CTRL2, 8'h04);
    $display("test periodic modes done");
    end_sim();
  end
endmodule
